// >>> logic/sfc_regs.vh
// Register map, field positions, reset values and codes of the synthesizer output block.
`ifndef SFC_REGS_VH
`define SFC_REGS_VH
`define SFC_ADDR_CTRL       4'h0
`define SFC_ADDR_REF_HOLD   4'h1
`define SFC_ADDR_MAIN_DIV   4'h2
`define SFC_ADDR_DAC        4'h3
`define SFC_ADDR_SEC_HOLD   4'h4
`define SFC_ADDR_SEC_REF    4'h5
`define SFC_LEN_CTRL        6'h08
`define SFC_LEN_REF_HOLD    6'h10
`define SFC_LEN_MAIN_DIV    6'h18
`define SFC_LEN_ADDRESSED   6'h20
`define SFC_CTRL_RESET      8'h02
`define SFC_HOLD_RESET      16'h0000
`define SFC_WIDE_RESET      24'h000000
`define SFC_CTRL_GP_LEVEL   7
`define SFC_CTRL_THREE_ST   6
`define SFC_CTRL_OPEN_DRN   5
`define SFC_CTRL_STANDBY    1
`define SFC_MAIN_AUX_SEL    23
`define SFC_SEC_MUX_HI      21
`define SFC_SEC_MUX_LO      20
`define SFC_MUX_STATIC      2'h0
`define SFC_MUX_MAIN_REF    2'h1
`define SFC_MUX_SEC_REF     2'h2
`define SFC_MUX_PULSE       2'h3
`define SFC_HALF_STEP_DEC   4'h5
`define SFC_HALF_STEP_WHOLE 4'h4
`define SFC_HALF_STEP_FIX   4'h5
`endif

// >>> logic/sfc_sync.v
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps
module sfc_sync (
    sys_clk,
    nrst,
    async_in,
    sync_out
);
    input  wire sys_clk;
    input  wire nrst;
    input  wire async_in;
    output wire sync_out;

    reg first_reg;
    reg second_reg;

    always @(posedge sys_clk) begin
        if (!nrst) begin
            first_reg  <= 1'b0;
            second_reg <= 1'b0;
        end else begin
            first_reg  <= async_in;
            second_reg <= first_reg;
        end
    end

    assign sync_out = second_reg;
endmodule

// >>> logic/sfc_aux_div.v
// Fractional divider for the auxiliary output: ratio given in half units of a reference tick.
`timescale 1ns/1ps
`include "sfc_regs.vh"
module sfc_aux_div (
    sys_clk,
    nrst,
    osc_tick,
    half_count,
    enable,
    aux_out
);
    input  wire       sys_clk;
    input  wire       nrst;
    input  wire       osc_tick;
    input  wire [4:0] half_count;
    input  wire       enable;
    output reg        aux_out;

    // Each tick adds four quarter units; a half period ends when half_count is reached.
    // A ratio of 12.5 thus yields halves of 7, 6, 6 and 6 ticks, exact over two periods.
    reg  [4:0] acc_reg;
    wire [5:0] acc_sum;

    assign acc_sum = {1'b0, acc_reg} + 6'h04;

    always @(posedge sys_clk) begin
        if (!nrst) begin
            acc_reg <= 5'h00;
            aux_out <= 1'b0;
        end else if (!enable) begin
            acc_reg <= 5'h00;
            aux_out <= 1'b0;
        end else if (osc_tick) begin
            if (acc_sum >= {1'b0, half_count}) begin
                acc_reg <= acc_sum[4:0] - half_count;
                aux_out <= ~aux_out;
            end else begin
                acc_reg <= acc_sum[4:0];
            end
        end
    end
endmodule

// >>> logic/sfc_top.v
// Serial register port and output steering of the dual-loop synthesizer.
//
// Overview of operation
// - Two secondary reference bits pick the multi-purpose output source: static, main, secondary, pulse.
// - Static mode drives the multi-purpose output at control bit 7's level.
// - Secondary divider and pulse indicator sources rest low and pulse high.
// - Length-selected access: 8, 16, 24 clocks write control, ref holding, main divider.
// - Addressed access uses 32 clocks; nibble 0 to 5 selects the six registers.
// - Strap low: dual pins output divided oscillator, fixed prescaler, positive polarities.
// - Secondary ratio steps by 2 strap low, by 0.5 strap high; reset loads 2.5.
// - Auxiliary ratio: bit 23 clear gives 10 or 12.5, set gives 8 or 10.
// - Open-drain output pulled low when control bit 5 is 0, else released.
// - Three-state output: low, high, or released with main loop standby; default standby.
// - Strap high: main polarity follows its input; strap low: positive.
// - Strap high: secondary polarity follows its input; strap low: positive.
// - Control bit 6 drives three-state output only with strap low; else reference select.
// - Bits arrive most significant first, sampled on the shift clock rising edge.
// - The shifted word is committed only when the serial enable returns high.
`timescale 1ns/1ps
`include "sfc_regs.vh"
module sfc_top (
    sys_clk,
    nrst,
    ser_en_n,
    ser_clk,
    ser_data,
    mode_strap,
    osc_tick,
    main_ref_div_in,
    sec_ref_div_in,
    det_pulse_in,
    pol_main_in,
    pol_sec_in,
    multi_out,
    open_drain_oe,
    three_state_out,
    three_state_oe,
    aux_divided_out,
    aux_divided_out_n,
    aux_oe,
    main_standby,
    ext_ref_sel,
    main_pol_neg,
    sec_pol_neg,
    sec_dual_modulus,
    sec_half_steps,
    dac_value,
    ref_ratio_holding,
    sec_ratio_holding,
    main_divider,
    sec_reference
);
    input  wire        sys_clk;
    input  wire        nrst;
    input  wire        ser_en_n;
    input  wire        ser_clk;
    input  wire        ser_data;
    input  wire        mode_strap;
    input  wire        osc_tick;
    input  wire        main_ref_div_in;
    input  wire        sec_ref_div_in;
    input  wire        det_pulse_in;
    input  wire        pol_main_in;
    input  wire        pol_sec_in;
    output reg         multi_out;
    output reg         open_drain_oe;
    output reg         three_state_out;
    output reg         three_state_oe;
    output reg         aux_divided_out;
    output reg         aux_divided_out_n;
    output reg         aux_oe;
    output reg         main_standby;
    output reg         ext_ref_sel;
    output reg         main_pol_neg;
    output reg         sec_pol_neg;
    output reg         sec_dual_modulus;
    output reg  [3:0]  sec_half_steps;
    output reg  [15:0] dac_value;
    output reg  [15:0] ref_ratio_holding;
    output reg  [15:0] sec_ratio_holding;
    output reg  [23:0] main_divider;
    output reg  [23:0] sec_reference;

    // The serial port, strap and polarity inputs are brought into the sys_clk domain first.
    wire en_n_s;
    wire sclk_s;
    wire sdat_s;
    wire strap_s;
    wire pol_m_s;
    wire pol_s_s;
    wire aux_raw;

    sfc_sync u_sync_en   (.sys_clk(sys_clk), .nrst(nrst), .async_in(ser_en_n),   .sync_out(en_n_s));
    sfc_sync u_sync_clk  (.sys_clk(sys_clk), .nrst(nrst), .async_in(ser_clk),    .sync_out(sclk_s));
    sfc_sync u_sync_dat  (.sys_clk(sys_clk), .nrst(nrst), .async_in(ser_data),   .sync_out(sdat_s));
    sfc_sync u_sync_mode (.sys_clk(sys_clk), .nrst(nrst), .async_in(mode_strap), .sync_out(strap_s));
    sfc_sync u_sync_pm   (.sys_clk(sys_clk), .nrst(nrst), .async_in(pol_main_in), .sync_out(pol_m_s));
    sfc_sync u_sync_ps   (.sys_clk(sys_clk), .nrst(nrst), .async_in(pol_sec_in), .sync_out(pol_s_s));

    reg [7:0]  control_byte_reg;
    reg [31:0] shift_reg;
    reg [5:0]  bit_cnt_reg;
    reg        sclk_d_reg;
    reg        en_d_reg;
    reg [4:0]  aux_half_reg;

    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire en_rise   = en_n_s & ~en_d_reg;
    wire [1:0] mux_sel = sec_reference[`SFC_SEC_MUX_HI:`SFC_SEC_MUX_LO];
    wire [3:0] nibble  = shift_reg[31:28];

    // Counts saturate at 63 so an overlong frame cannot alias onto a valid length.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            shift_reg   <= 32'h00000000;
            bit_cnt_reg <= 6'h00;
            sclk_d_reg  <= 1'b0;
            en_d_reg    <= 1'b1;
        end else begin
            sclk_d_reg <= sclk_s;
            en_d_reg   <= en_n_s;
            if (en_n_s) begin
                if (!en_rise) begin
                    bit_cnt_reg <= 6'h00;
                end
            end else if (sclk_rise) begin
                shift_reg <= {shift_reg[30:0], sdat_s};
                if (bit_cnt_reg != 6'h3f) begin
                    bit_cnt_reg <= bit_cnt_reg + 6'h01;
                end
            end
        end
    end

    // Register commit on the enable's return high.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            control_byte_reg  <= `SFC_CTRL_RESET;
            ref_ratio_holding <= `SFC_HOLD_RESET;
            main_divider      <= `SFC_WIDE_RESET;
            dac_value         <= `SFC_HOLD_RESET;
            sec_ratio_holding <= `SFC_HOLD_RESET;
            sec_reference     <= `SFC_WIDE_RESET;
        end else if (en_rise) begin
            case (bit_cnt_reg)
                `SFC_LEN_CTRL:     control_byte_reg  <= shift_reg[7:0];
                `SFC_LEN_REF_HOLD: ref_ratio_holding <= shift_reg[15:0];
                `SFC_LEN_MAIN_DIV: main_divider      <= shift_reg[23:0];
                `SFC_LEN_ADDRESSED: begin
                    case (nibble)
                        `SFC_ADDR_CTRL:     control_byte_reg  <= shift_reg[7:0];
                        `SFC_ADDR_REF_HOLD: ref_ratio_holding <= shift_reg[15:0];
                        `SFC_ADDR_MAIN_DIV: main_divider      <= shift_reg[23:0];
                        `SFC_ADDR_DAC:      dac_value         <= shift_reg[15:0];
                        `SFC_ADDR_SEC_HOLD: sec_ratio_holding <= shift_reg[15:0];
                        `SFC_ADDR_SEC_REF:  sec_reference     <= shift_reg[23:0];
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    end

    // Auxiliary ratio in half units: 16, 20 or 25 halves of the reference.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            aux_half_reg <= 5'h14;
        end else if (main_divider[`SFC_MAIN_AUX_SEL]) begin
            aux_half_reg <= (sec_reference[1:0] == 2'h0) ? 5'h10 : 5'h14;
        end else begin
            aux_half_reg <= (sec_reference[1:0] == 2'h0) ? 5'h14 : 5'h19;
        end
    end

    sfc_aux_div u_aux (
        .sys_clk   (sys_clk),
        .nrst      (nrst),
        .osc_tick  (osc_tick),
        .half_count(aux_half_reg),
        .enable    (~strap_s),
        .aux_out   (aux_raw)
    );

    // Output steering; every pin-facing level leaves from a flip-flop.
    always @(posedge sys_clk) begin
        if (!nrst) begin
            multi_out         <= 1'b0;
            open_drain_oe     <= 1'b1;
            three_state_out   <= 1'b0;
            three_state_oe    <= 1'b0;
            aux_divided_out   <= 1'b0;
            aux_divided_out_n <= 1'b1;
            aux_oe            <= 1'b0;
            main_standby      <= 1'b1;
            ext_ref_sel       <= 1'b0;
            main_pol_neg      <= 1'b0;
            sec_pol_neg       <= 1'b0;
            sec_dual_modulus  <= 1'b0;
            sec_half_steps    <= `SFC_HALF_STEP_DEC;
        end else begin
            case (mux_sel)
                `SFC_MUX_STATIC:   multi_out <= control_byte_reg[`SFC_CTRL_GP_LEVEL];
                `SFC_MUX_MAIN_REF: multi_out <= main_ref_div_in;
                `SFC_MUX_SEC_REF:  multi_out <= sec_ref_div_in;
                `SFC_MUX_PULSE:    multi_out <= det_pulse_in;
                default:           multi_out <= 1'b0;
            endcase
            open_drain_oe <= ~control_byte_reg[`SFC_CTRL_OPEN_DRN];
            main_standby  <= control_byte_reg[`SFC_CTRL_STANDBY];
            // Output B only meaningful with strap low; otherwise bit 6 picks the reference.
            three_state_oe  <= ~strap_s & ~control_byte_reg[`SFC_CTRL_STANDBY];
            three_state_out <= ~strap_s & control_byte_reg[`SFC_CTRL_THREE_ST];
            ext_ref_sel     <= strap_s & control_byte_reg[`SFC_CTRL_THREE_ST];
            // Strap follows its synchronised level every cycle, never latched once.
            aux_oe            <= ~strap_s;
            aux_divided_out   <= ~strap_s & aux_raw;
            aux_divided_out_n <= ~strap_s & ~aux_raw;
            main_pol_neg      <= strap_s & pol_m_s;
            sec_pol_neg       <= strap_s & pol_s_s;
            sec_dual_modulus  <= strap_s;
            sec_half_steps    <= strap_s ? 4'h1 : `SFC_HALF_STEP_WHOLE;
        end
    end
endmodule

// >>> testbench/sfc_top_checker.sv
// Port-level assertions for the synthesizer serial port and output steering.
`timescale 1ns/1ps
module sfc_top_checker (
    input logic        sys_clk,
    input logic        nrst,
    input logic        ser_en_n,
    input logic        pol_main_in,
    input logic        pol_sec_in,
    input logic        three_state_oe,
    input logic        aux_divided_out,
    input logic        aux_divided_out_n,
    input logic        aux_oe,
    input logic        main_standby,
    input logic        ext_ref_sel,
    input logic        main_pol_neg,
    input logic        sec_pol_neg,
    input logic        sec_dual_modulus,
    input logic [3:0]  sec_half_steps,
    input logic [15:0] dac_value,
    input logic [15:0] ref_ratio_holding,
    input logic [15:0] sec_ratio_holding,
    input logic [23:0] main_divider,
    input logic [23:0] sec_reference
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire [95:0] regs_all = {dac_value, ref_ratio_holding, sec_ratio_holding, main_divider,
                            sec_reference};
    // Two cycles of slack let the synchronised strap settle before its effects are judged.
    sequence strap_high; sec_dual_modulus [*2]; endsequence
    sequence strap_low; !sec_dual_modulus [*2]; endsequence
    sequence main_pol_held; (sec_dual_modulus && $stable(pol_main_in)) [*5]; endsequence
    sequence sec_pol_held; (sec_dual_modulus && $stable(pol_sec_in)) [*5]; endsequence
    AST_EXT_REF: assert property (ext_ref_sel |-> sec_dual_modulus || $past(sec_dual_modulus))
        else $error("reference select active with strap low");
    AST_POL_DEFAULT: assert property (strap_low |-> !main_pol_neg && !sec_pol_neg)
        else $error("polarity not positive with strap low");
    AST_POL_MAIN: assert property (main_pol_held |-> main_pol_neg == pol_main_in)
        else $error("main polarity does not follow its input");
    AST_POL_SEC: assert property (sec_pol_held |-> sec_pol_neg == pol_sec_in)
        else $error("secondary polarity does not follow its input");
    AST_AUX_DIR: assert property (strap_high |-> !aux_oe)
        else $error("dual-purpose pins driven with strap high");
    AST_HALF_HIGH: assert property (strap_high |-> sec_half_steps == 4'h1)
        else $error("ratio step not half with strap high");
    AST_HALF_LOW: assert property (strap_low |-> sec_half_steps inside {4'h4, 4'h5})
        else $error("ratio step wrong with strap low");
    AST_AUX_DIFF: assert property (aux_oe |-> aux_divided_out != aux_divided_out_n)
        else $error("divided output pair not complementary");
    AST_STANDBY: assert property (three_state_oe |-> !main_standby)
        else $error("three-state output driven in standby");
    AST_COMMIT: assert property (!$stable(regs_all) |-> ser_en_n && $past(ser_en_n, 3))
        else $error("register changed inside an enable window");
endmodule
bind sfc_top sfc_top_checker sfc_top_checker_i (.*);

// >>> testbench/sfc_mcu_model.sv
// Microcontroller model that shifts frames into the three-wire serial port.
`timescale 1ns/1ps
module sfc_mcu_model (
    input  logic sys_clk,
    output logic ser_en_n = 1'b1,
    output logic ser_clk  = 1'b0,
    output logic ser_data = 1'b0
);
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // The shift clock stays low outside frames, so the enable never moves while it is high.
    task automatic send(input int n, input logic [31:0] w);
        ser_en_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            hold(3);
            ser_data <= w[i];
            hold(3);
            ser_clk <= 1'b1;
            hold(3);
            ser_clk <= 1'b0;
        end
        hold(3);
        ser_en_n <= 1'b1;
        ser_data <= ~w[0];
        hold(8);
    endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the synthesizer serial port and output steering.
`timescale 1ns/1ps
module tb;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        mode_strap = 1'b0;
    logic        osc_tick = 1'b0;
    logic        main_ref_div_in = 1'b1;
    logic        sec_ref_div_in = 1'b0;
    logic        det_pulse_in = 1'b1;
    logic        pol_main_drv = 1'b0;
    logic        pol_sec_drv = 1'b0;
    wire         ser_en_n, ser_clk, ser_data, multi_out, open_drain_oe, three_state_out;
    wire         three_state_oe, aux_divided_out, aux_divided_out_n, aux_oe, main_standby;
    wire         ext_ref_sel, main_pol_neg, sec_pol_neg, sec_dual_modulus;
    wire [3:0]   sec_half_steps;
    wire [15:0]  dac_value, ref_ratio_holding, sec_ratio_holding;
    wire [23:0]  main_divider, sec_reference;
    // While the pins are outputs the bench stops driving them and reads the device back.
    wire         pol_main_in = aux_oe ? aux_divided_out_n : pol_main_drv;
    wire         pol_sec_in = aux_oe ? aux_divided_out : pol_sec_drv;
    int          miscompares = 0;
    int          total_checks = 0;
    sfc_top sfc_top_i (.*);
    sfc_mcu_model sfc_mcu_model_i (.*);
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) osc_tick <= ~osc_tick;
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Ticks come every second cycle, so two output periods span four times the ratio.
    task automatic span(input int exp);
        realtime t0;
        repeat (2) @(posedge aux_divided_out);
        t0 = $realtime;
        repeat (2) @(posedge aux_divided_out);
        check("aux span", exp, int'(($realtime - t0) / 100.0));
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        check("defaults", 4'ha, {open_drain_oe, three_state_oe, main_standby, multi_out});
        $display("test reset done");
        sfc_mcu_model_i.send(8, 8'ha0);
        check("ctrl a0", 4'h5, {open_drain_oe, three_state_oe, three_state_out, multi_out});
        sfc_mcu_model_i.send(8, 8'h42);
        check("ctrl 42", 2'h2, {main_standby, three_state_oe});
        sfc_mcu_model_i.send(8, 8'h40);
        check("ctrl 40", 4'he, {open_drain_oe, three_state_oe, three_state_out, multi_out});
        $display("test control done");
        sfc_mcu_model_i.send(16, 16'hbeef);
        check("ref hold", 24'h00beef, ref_ratio_holding);
        sfc_mcu_model_i.send(24, 24'h800123);
        check("main div", 24'h800123, main_divider);
        for (int a = 0; a < 6; a++)
            sfc_mcu_model_i.send(32, {a[3:0], 28'h00a5c30 | 28'(a)});
        sfc_mcu_model_i.send(12, 12'hfff);
        sfc_mcu_model_i.send(32, 32'h60ffffff);
        check("ctrl 32", 2'h1, {open_drain_oe, three_state_oe});
        check("ref 32", 24'h005c31, ref_ratio_holding);
        check("main 32", 24'h0a5c32, main_divider);
        check("dac 32", 24'h005c33, dac_value);
        check("sec hold", 24'h005c34, sec_ratio_holding);
        check("sec ref", 24'h0a5c35, sec_reference);
        $display("test access done");
        for (int c = 0; c < 4; c++) begin
            sfc_mcu_model_i.send(32, {10'h140, c[1:0], 20'h0});
            check("mux", c[0], multi_out);
        end
        for (int k = 0; k < 4; k++) begin
            sfc_mcu_model_i.send(24, {k[1], 23'h0});
            sfc_mcu_model_i.send(32, {8'h50, 22'h0, k[0], k[0]});
            span((k == 1) ? 50 : (k == 2) ? 32 : 40);
        end
        $display("test steering done");
        mode_strap <= 1'b1;
        pol_main_drv <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check("strap hi", 9'h141, {sec_dual_modulus, aux_oe, main_pol_neg, sec_pol_neg,
                                   ext_ref_sel, sec_half_steps});
        sfc_mcu_model_i.send(8, 8'h40);
        pol_main_drv <= 1'b0;
        pol_sec_drv <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check("pol swap", 3'h3, {main_pol_neg, sec_pol_neg, ext_ref_sel});
        mode_strap <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check("strap lo", 3'h4, {aux_oe, main_pol_neg, sec_pol_neg});
        $display("test strap done");
        conclude();
    end
    initial begin
        #3_000_000;
        miscompares++;
        conclude();
    end
endmodule
